// ---- serial_peripheral_shift_port_tb.sv ----
`timescale 1ns/10ps
module serial_peripheral_shift_port_tb;
   localparam logic [9:0] A_MISC = {spsp_pkg::SPSP_IDX_MISC, 2'b00};
   localparam logic [9:0] A_DSR  = {spsp_pkg::SPSP_IDX_DSR, 2'b00};
   localparam logic [9:0] A_DIV  = {spsp_pkg::SPSP_IDX_DIV, 2'b00};
   localparam logic [9:0] A_MOD  = {spsp_pkg::SPSP_IDX_MOD, 2'b00};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   spsp_pkg::spsp_wb_req_s wb_i = '0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, sout_pin_o, sout_pin_oe_o, sck_o, sck_oe_o, irq_o;
   logic sck_i = 1'b0;
   logic line_four_dir_out_i = 1'b0;
   logic line_three_gpio_dat_i = 1'b1;
   logic line_three_gpio_oe_i = 1'b1;
   logic peer_inv = 1'b0;
   logic tb_sin = 1'b0;
   logic use_tb = 1'b0;
   logic load = 1'b0;
   logic [7:0] tx = 8'h00;
   logic [7:0] q, rx;
   logic [4:0] edges, e;
   logic [9:0] period;
   logic sin_m;
   wire logic sin_i = use_tb ? tb_sin : sin_m;
   int n_mismatch = 0;
   int total_checks = 0;
   always #2.5 clk_i = ~clk_i;
   spsp_top i_spsp_top (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .sin_i(sin_i), .sck_i(sck_i), .line_four_dir_out_i(line_four_dir_out_i),
      .line_three_gpio_dat_i(line_three_gpio_dat_i), .line_three_gpio_oe_i(line_three_gpio_oe_i),
      .sout_pin_o(sout_pin_o), .sout_pin_oe_o(sout_pin_oe_o),
      .sck_o(sck_o), .sck_oe_o(sck_oe_o), .irq_o(irq_o));
   spsp_peer i_spsp_peer (.clk_i(clk_i), .sck_i(sck_o ^ peer_inv), .sout_i(sout_pin_o), .load_i(load), .tx_i(tx),
      .sin_o(sin_m), .rx_o(rx), .edges_o(edges), .period_o(period));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task wb(input logic we, input logic [9:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wb_i <= '{cyc:1'b1, stb:1'b1, we:we, sel:4'hF, adr:a, dat:{24'h000000, d}};
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o[7:0];
      wb_i <= '0;
   endtask : wb
   task wr(input logic [9:0] a, input logic [7:0] d);
      wb(1'b1, a, d);
   endtask : wr
   task rd(input logic [9:0] a);
      wb(1'b0, a, 8'h00);
   endtask : rd
   task ld(input logic [7:0] v);
      tx <= v;
      load <= 1'b1;
      @(posedge clk_i);
      load <= 1'b0;
   endtask : ld
   task wait_idle;
      int n;
      n = 0;
      do begin
         rd(A_MOD);
         n++;
      end while (q[7] !== 1'b0 && n < 400);
      chk("run idle", q[7], 1'b0);
   endtask : wait_idle
   task t_reset;
      rd(A_MOD); chk("mod", q, 8'h00);
      rd(A_DIV); chk("div", q, 8'h00);
      rd(10'h3FC); chk("unmapped", q, 8'h00);
      chk("gpio pin", sout_pin_o, 1'b1);
      chk("gpio oe", sout_pin_oe_o, 1'b1);
      wr(A_MOD, 8'h5E); rd(A_MOD); chk("mod rw", q, 8'h5E);
      wr(A_MOD, 8'h00);
   endtask : t_reset
   task t_master;
      line_four_dir_out_i <= 1'b1;
      wr(A_MOD, 8'h0A); repeat (2) @(posedge clk_i);
      chk("idle sck", sck_o, 1'b1);
      wr(A_MOD, 8'h02);
      wr(A_MISC, 8'h01); wr(A_DSR, 8'hA5); wr(A_DIV, 8'h41); ld(8'h3C);
      wr(A_MOD, 8'hD2); repeat (2) @(posedge clk_i);
      chk("sck oe", sck_oe_o, 1'b1);
      chk("sout oe", sout_pin_oe_o, 1'b1);
      wait_idle;
      rd(A_DSR); chk("rx", q, 8'h3C);
      chk("peer rx", rx, 8'hA5);
      chk("bits", edges, 5'h08);
      chk("period", period, 10'h034);
      rd(A_DIV); chk("flag", q, 8'hC1);
      rd(A_MOD); chk("run clr", q, 8'h52);
      chk("irq", irq_o, 1'b1);
      wr(A_DIV, 8'h41); @(posedge clk_i);
      chk("irq clr", irq_o, 1'b0);
   endtask : t_master
   task t_short;
      wr(A_DSR, 8'hFF); wr(A_DIV, 8'h18); ld(8'h00);
      wr(A_MOD, 8'h82); wait_idle;
      rd(A_DSR); chk("zeros in", q, 8'hF8);
      chk("bits", edges, 5'h03);
      chk("peer rx", rx[2:0], 3'b111);
      rd(A_DIV); chk("flag", q, 8'h98);
      chk("irq masked", irq_o, 1'b0);
      wr(A_DIV, 8'h18);
   endtask : t_short
   task t_abort;
      wr(A_DIV, 8'h40); ld(8'h00); wr(A_MOD, 8'hC2);
      repeat (60) @(posedge clk_i);
      wr(A_MOD, 8'h42); repeat (2) @(posedge clk_i);
      chk("abort irq", irq_o, 1'b1);
      e = edges;
      repeat (100) @(posedge clk_i);
      chk("stopped", edges, e);
      chk("early", e < 5'h08, 1'b1);
      rd(A_DIV); chk("flag", q, 8'hC0);
      wr(A_DIV, 8'h40);
   endtask : t_abort
   task t_xstart;
      use_tb <= 1'b1;
      tb_sin <= 1'b0;
      wr(A_DIV, 8'h10); ld(8'h00);
      wr(A_MOD, 8'hA2);
      repeat (100) @(posedge clk_i);
      chk("no start", edges, 5'h00);
      tb_sin <= 1'b1;
      repeat (5) @(posedge clk_i);
      tb_sin <= 1'b0;
      wait_idle; chk("bits", edges, 5'h02);
      wr(A_DIV, 8'h10);
   endtask : t_xstart
   task t_slave;
      line_four_dir_out_i <= 1'b0;
      tb_sin <= 1'b1;
      wr(A_DSR, 8'h00); wr(A_DIV, 8'h08); wr(A_MOD, 8'h90);
      repeat (2) @(posedge clk_i);
      chk("slave oe", sck_oe_o, 1'b0);
      sck_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      sck_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      rd(A_DSR); chk("slave rx", q, 8'h01);
      rd(A_MOD); chk("slave end", q, 8'h10);
      use_tb <= 1'b0;
   endtask : t_slave
   task t_phase;
      line_four_dir_out_i <= 1'b1;
      peer_inv            <= 1'b1;
      wr(A_MOD, 8'h0E); wr(A_DSR, 8'hC3); wr(A_DIV, 8'h22); ld(8'hA0);
      wr(A_MOD, 8'hDE); wait_idle;
      rd(A_DSR); chk("phase rx", q, 8'h3A);
      chk("phase peer rx", rx[3:0], 4'hC);
      chk("phase bits", edges, 5'h04);
      chk("phase period", period, 10'h068);
      rd(A_DIV); chk("phase flag", q, 8'hA2);
      chk("phase irq", irq_o, 1'b1);
      wr(A_DIV, 8'h22);
   endtask : t_phase
   task results;
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_master;
      t_short;
      t_abort;
      t_xstart;
      t_slave;
      t_phase;
      results;
   end
   initial begin
      #100000;
      n_mismatch++;
      results;
   end
endmodule : serial_peripheral_shift_port_tb

// ---- spsp_peer.sv ----
`timescale 1ns/10ps
module spsp_peer (
   input  wire logic       clk_i,
   input  wire logic       sck_i,
   input  wire logic       sout_i,
   input  wire logic       load_i,
   input  wire logic [7:0] tx_i,
   output logic            sin_o,
   output logic [7:0]      rx_o,
   output logic [4:0]      edges_o,
   output logic [9:0]      period_o
);
   logic       prev_r;
   logic [7:0] sh_r;
   logic [9:0] cnt_r;
   wire  logic rise = sck_i & ~prev_r;
   wire  logic fall = ~sck_i & prev_r;
   assign sin_o = sh_r[7];
   always @(posedge clk_i) begin
      prev_r <= sck_i;
      cnt_r  <= rise ? 10'h000 : cnt_r + 10'h001;
      if (rise) begin
         rx_o     <= {rx_o[6:0], sout_i};
         edges_o  <= edges_o + 5'h01;
         period_o <= cnt_r + 10'h001;
      end
      if (load_i) begin
         sh_r    <= tx_i;
         edges_o <= 5'h00;
      end
      else if (fall) sh_r <= {sh_r[6:0], ~sh_r[0]};
   end
endmodule : spsp_peer

// ---- spsp_pkg.sv ----
package spsp_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] SPSP_IDX_MISC    = 8'hDD;
   localparam logic [7:0] SPSP_IDX_DSR     = 8'hE0;
   localparam logic [7:0] SPSP_IDX_DIV     = 8'hE1;
   localparam logic [7:0] SPSP_IDX_MOD     = 8'hE2;
   localparam int         SPSP_ADR_W       = 10;
   // Mode control fields
   localparam int         SPSP_MOD_RUN     = 7;
   localparam int         SPSP_MOD_IE      = 6;
   localparam int         SPSP_MOD_XSTART  = 5;
   localparam int         SPSP_MOD_RXEN    = 4;
   localparam int         SPSP_MOD_CPOL    = 3;
   localparam int         SPSP_MOD_CPHA    = 2;
   localparam int         SPSP_MOD_CLKSRC  = 1;
   localparam int         SPSP_MOD_FILT    = 0;
   // Divide and misc register fields
   localparam int         SPSP_DIV_FLAG    = 7;
   localparam int         SPSP_DIV_LEN_LSB = 3;
   localparam int         SPSP_DIV_CD_LSB  = 0;
   localparam int         SPSP_MISC_SOUT   = 0;
   // Reset values
   localparam logic [7:0] SPSP_MOD_RST     = 8'h00;
   localparam logic [7:0] SPSP_DIV_RST     = 8'h00;
   localparam logic [7:0] SPSP_DSR_RST     = 8'h00;
   localparam logic [7:0] SPSP_MISC_RST    = 8'h00;
   // Core cycle prescaler in clock cycles
   localparam int         SPSP_PRESCALE    = 13;
   localparam logic [3:0] SPSP_PRE_LAST    = 4'(SPSP_PRESCALE - 1);

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [9:0]  adr;
      logic [31:0] dat;
   } spsp_wb_req_s;

   typedef enum logic [1:0] {
      SPSP_IDLE  = 2'b00,
      SPSP_ARMED = 2'b01,
      SPSP_SHIFT = 2'b10
   } spsp_state_e;
endpackage : spsp_pkg

// ---- spsp_top.sv ----
// Chosen here: register access over Wishbone.
`timescale 1ns/10ps
// Behaviour
// - Data/shift, divide and mode registers at indices E0h, E1h, E2h.
// - Master clock is core clock over 13, then programmable ratio.
// - Slave takes external shift clock; master may disable data input.
// - Sampling edge and data phase are programmable.
// - Data in, data out, clock sit on port C lines two to four.
// - Data out reaches pin only while misc bit 0 is one.
// - Clock is input when port line is input and source bit zero.
// - Clock is driven when port line is output and source bit one.
// - End of transfer requests interrupt vector 2, maskable by enable.
// - Divide register holds a flag telling serial from port interrupts.
// - Mode register fully read/write, cleared by reset.
// - Activity flag self-clears at transfer end and raises request.
// - Software clearing activity flag stops transfer and raises request.
// - Activity flag with external start select forms start command.
// - Interrupt enable passes or blocks the serial request.
// - External start needs data input high, then ignores its fall.
// - Receive enable zero shifts zeros, one shifts data input.
// - Most significant bit goes and comes first.
// - Four-bit field sets frame of 1 to 15 bits; zero gives 16 bits.
module spsp_top #(
   parameter int DATA_W = 8
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire spsp_pkg::spsp_wb_req_s wb_i,
   output logic [31:0]               wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic                 sin_i,
   input  wire logic                 sck_i,
   input  wire logic                 line_four_dir_out_i,
   input  wire logic                 line_three_gpio_dat_i,
   input  wire logic                 line_three_gpio_oe_i,
   output logic                      sout_pin_o,
   output logic                      sout_pin_oe_o,
   output logic                      sck_o,
   output logic                      sck_oe_o,
   output logic                      irq_o
);
   logic [DATA_W-1:0]     dsr_r;
   logic [7:0]            div_r;
   logic [7:0]            mod_r;
   logic                  misc_r;
   logic                  out_r;
   logic                  sck_lvl_r;
   logic                  sck_q_r;
   logic [3:0]            pre_r;
   logic [8:0]            dcnt_r;
   logic [3:0]            bits_r;
   logic                  in_r;
   spsp_pkg::spsp_state_e state_r;
   spsp_pkg::spsp_state_e state_nxt;

   // Bus decode
   wire       req      = wb_i.cyc & wb_i.stb & ~wb_ack_o;
   wire [7:0] idx      = wb_i.adr[9:2];
   wire       wr       = req & wb_i.we & wb_i.sel[0];
   wire       wr_mod   = wr & (idx == spsp_pkg::SPSP_IDX_MOD);
   wire       wr_div   = wr & (idx == spsp_pkg::SPSP_IDX_DIV);
   wire       wr_dsr   = wr & (idx == spsp_pkg::SPSP_IDX_DSR);
   wire       wr_misc  = wr & (idx == spsp_pkg::SPSP_IDX_MISC);
   wire [7:0] wd       = wb_i.dat[7:0];

   wire       run      = mod_r[spsp_pkg::SPSP_MOD_RUN];
   wire       ie       = mod_r[spsp_pkg::SPSP_MOD_IE];
   wire       xstart   = mod_r[spsp_pkg::SPSP_MOD_XSTART];
   wire       rxen     = mod_r[spsp_pkg::SPSP_MOD_RXEN];
   wire       cpol     = mod_r[spsp_pkg::SPSP_MOD_CPOL];
   wire       cpha     = mod_r[spsp_pkg::SPSP_MOD_CPHA];
   wire       clksrc   = mod_r[spsp_pkg::SPSP_MOD_CLKSRC];
   wire       flag     = div_r[spsp_pkg::SPSP_DIV_FLAG];
   wire [3:0] len      = div_r[spsp_pkg::SPSP_DIV_LEN_LSB +: 4];
   wire [2:0] cd       = div_r[spsp_pkg::SPSP_DIV_CD_LSB +: 3];

   wire       slave_en  = ~clksrc & ~line_four_dir_out_i;
   wire       master_en = clksrc & line_four_dir_out_i;
   wire       busy      = (state_r == spsp_pkg::SPSP_SHIFT);

   wire [8:0] ratio     = (cd == 3'h7) ? 9'h100 : (9'h001 << cd);
   wire       base_tick = busy & (pre_r == spsp_pkg::SPSP_PRE_LAST);
   wire       edge_tick = base_tick & (dcnt_r == ratio - 9'h001);

   wire       sl_chg    = slave_en & busy & (sck_i != sck_q_r);
   wire       lead      = master_en ? (edge_tick & (sck_lvl_r == cpol))
                                    : (sl_chg & (sck_i != cpol));
   wire       trail     = master_en ? (edge_tick & (sck_lvl_r != cpol))
                                    : (sl_chg & (sck_i == cpol));

   wire       rx_bit    = rxen & sin_i;
   wire       shift_in  = rxen & (cpha ? sin_i : in_r);
   wire       last_bit  = trail & (bits_r + 4'h1 == len);
   wire       sw_stop   = busy & wr_mod & ~wd[spsp_pkg::SPSP_MOD_RUN];
   wire       done      = (last_bit & ~wr_mod) | sw_stop;
   wire       go        = run & (~xstart | sin_i);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         spsp_pkg::SPSP_IDLE: begin
            if (go) begin
               state_nxt = spsp_pkg::SPSP_SHIFT;
            end else if (run) begin
               state_nxt = spsp_pkg::SPSP_ARMED;
            end
         end
         spsp_pkg::SPSP_ARMED: begin
            if (!run) begin
               state_nxt = spsp_pkg::SPSP_IDLE;
            end else if (sin_i) begin
               state_nxt = spsp_pkg::SPSP_SHIFT;
            end
         end
         spsp_pkg::SPSP_SHIFT: begin
            if (done) begin
               state_nxt = spsp_pkg::SPSP_IDLE;
            end
         end
         default: state_nxt = spsp_pkg::SPSP_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= spsp_pkg::SPSP_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mod_r <= spsp_pkg::SPSP_MOD_RST;
      end else if (wr_mod) begin
         mod_r <= wd;
      end else if (last_bit) begin
         mod_r[spsp_pkg::SPSP_MOD_RUN] <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_r <= spsp_pkg::SPSP_DIV_RST;
      end else begin
         if (wr_div && !run) begin
            div_r[6:0] <= wd[6:0];
         end
         if (done) begin
            div_r[spsp_pkg::SPSP_DIV_FLAG] <= 1'b1;
         end else if (wr_div && !wd[spsp_pkg::SPSP_DIV_FLAG]) begin
            div_r[spsp_pkg::SPSP_DIV_FLAG] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         misc_r <= spsp_pkg::SPSP_MISC_RST[spsp_pkg::SPSP_MISC_SOUT];
      end else if (wr_misc) begin
         misc_r <= wd[spsp_pkg::SPSP_MISC_SOUT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dsr_r <= spsp_pkg::SPSP_DSR_RST;
      end else if (wr_dsr && !run) begin
         dsr_r <= wd[DATA_W-1:0];
      end else if (trail) begin
         dsr_r <= {dsr_r[DATA_W-2:0], shift_in};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_r  <= 1'b0;
         out_r <= 1'b0;
      end else if (lead) begin
         in_r  <= rx_bit;
         out_r <= dsr_r[DATA_W-1];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !busy) begin
         bits_r <= 4'h0;
      end else if (trail) begin
         bits_r <= bits_r + 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !busy) begin
         pre_r  <= 4'h0;
         dcnt_r <= 9'h000;
      end else if (base_tick) begin
         pre_r  <= 4'h0;
         dcnt_r <= edge_tick ? 9'h000 : dcnt_r + 9'h001;
      end else begin
         pre_r  <= pre_r + 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_lvl_r <= 1'b0;
         sck_q_r   <= 1'b0;
      end else begin
         sck_lvl_r <= busy ? (sck_lvl_r ^ edge_tick) : cpol;
         sck_q_r   <= sck_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sout_pin_o    <= 1'b0;
         sout_pin_oe_o <= 1'b0;
         sck_o         <= 1'b0;
         sck_oe_o      <= 1'b0;
         irq_o         <= 1'b0;
      end else begin
         sout_pin_o    <= misc_r ? (cpha ? out_r : dsr_r[DATA_W-1]) : line_three_gpio_dat_i;
         sout_pin_oe_o <= misc_r | line_three_gpio_oe_i;
         sck_o         <= sck_lvl_r;
         sck_oe_o      <= master_en;
         irq_o         <= flag & ie;
      end
   end

   wire [7:0] rd_mux = (idx == spsp_pkg::SPSP_IDX_MOD)  ? mod_r :
                       (idx == spsp_pkg::SPSP_IDX_DIV)  ? div_r :
                       (idx == spsp_pkg::SPSP_IDX_DSR)  ? dsr_r :
                       (idx == spsp_pkg::SPSP_IDX_MISC) ? {7'h00, misc_r} : 8'h00;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= (req && !wb_i.we) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      end
   end

   // Assertions
   sequence s_req;
      wb_i.cyc && wb_i.stb && !wb_ack_o;
   endsequence
   sequence s_stop;
      busy && wr_mod && !wd[spsp_pkg::SPSP_MOD_RUN];
   endsequence

   property p_ack;
      @(posedge clk_i) disable iff (rst_i) s_req |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not single");

   property p_mod_rst;
      @(posedge clk_i) rst_i |=> mod_r == 8'h00;
   endproperty
   a_mod_rst: assert property (p_mod_rst) else $error("mode not cleared");

   property p_end;
      @(posedge clk_i) disable iff (rst_i) (last_bit && !wr_mod) |=> !run && flag && !busy;
   endproperty
   a_end: assert property (p_end) else $error("end not flagged");

   property p_stop;
      @(posedge clk_i) disable iff (rst_i) s_stop |=> !busy && flag ##1 irq_o == ie;
   endproperty
   a_stop: assert property (p_stop) else $error("stop failed");

   property p_irq;
      @(posedge clk_i) disable iff (rst_i) (flag && ie) |=> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");

   property p_mask;
      @(posedge clk_i) disable iff (rst_i) !ie |=> !irq_o;
   endproperty
   a_mask: assert property (p_mask) else $error("irq not masked");

   property p_xstart;
      @(posedge clk_i) disable iff (rst_i)
         (state_r == spsp_pkg::SPSP_ARMED && !sin_i) |=> state_r != spsp_pkg::SPSP_SHIFT;
   endproperty
   a_xstart: assert property (p_xstart) else $error("early start");

   property p_rxzero;
      @(posedge clk_i) disable iff (rst_i) (trail && !rxen && !wr_dsr) |=> dsr_r[0] == 1'b0;
   endproperty
   a_rxzero: assert property (p_rxzero) else $error("nonzero shifted");

   property p_msb;
      @(posedge clk_i) disable iff (rst_i) (misc_r && !cpha) |=> sout_pin_o == $past(dsr_r[DATA_W-1]);
   endproperty
   a_msb: assert property (p_msb) else $error("msb not out");

   property p_master;
      @(posedge clk_i) disable iff (rst_i) master_en |=> sck_oe_o;
   endproperty
   a_master: assert property (p_master) else $error("clock not driven");

   property p_pre;
      @(posedge clk_i) disable iff (rst_i) (base_tick && busy) |=> !base_tick [*8];
   endproperty
   a_pre: assert property (p_pre) else $error("prescale short");
endmodule : spsp_top
